// [hdl/rcwt_cycle_timer.sv]
// ROM and ISA cycle sequencer with command delay and wait-state timing
`timescale 1ns/1ps
`include "rcwt_defs.svh"
module rcwt_cycle_timer #(
  parameter int HALF_DIV = `RCWT_HALF_DIV
) (
  input logic i_clk,
  input logic i_rstn,
  input logic i_cfg_wr,
  input logic [7:0] i_cfg_index,
  input logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input logic i_req,
  input logic i_is_io,
  input logic i_wide,
  input logic i_paged,
  input logic [9:0] i_io_addr,
  input rcwt_pkg::rcwt_tgt_t i_tgt,
  input logic i_cpu_clk_stop,
  input logic i_max_isa,
  output logic o_busy,
  output logic o_done,
  output logic o_bus_clk,
  output logic o_addr_en,
  output logic o_bale,
  output logic o_cmd_n,
  output logic o_bios_rom_select_n,
  output logic o_dos_rom_select_n
);
  import rcwt_pkg::*;

  logic [7:0] rom_config_two_reg;
  logic [7:0] command_delay_ctl_reg;
  logic [7:0] io_wait_select_reg;
  logic [7:0] memory_wait_select_one_reg;
  logic [7:0] memory_wait_select_two_reg;
  logic [7:0] wait_control_reg;
  logic [7:0] misc_five_ctl_reg;
  logic [7:0] rom_config_three_reg;
  logic [3:0] div_reg;
  logic half_tick;
  logic step;
  logic stop_m_reg, stop_s_reg, max_m_reg, max_s_reg;
  rcwt_state_t state_reg;
  logic [3:0] h_reg;
  logic [3:0] start_reg;
  logic [3:0] end_reg;
  logic [2:0] dly_reg;
  logic [2:0] ws_reg;
  logic fast_reg;
  logic maxisa_reg;
  rcwt_tgt_t tgt_reg;
  logic io_reg;
  logic cmd_on;
  logic run_addr;

  rcwt_tim_if tif ();

  // Configuration and pending request feed the selector
  assign tif.cmd_dly = command_delay_ctl_reg;
  assign tif.io_wait = io_wait_select_reg;
  assign tif.mem_wait1 = memory_wait_select_one_reg;
  assign tif.mem_wait2 = memory_wait_select_two_reg;
  assign tif.wait_ctl = wait_control_reg;
  assign tif.misc5 = misc_five_ctl_reg;
  assign tif.rom_cfg3 = rom_config_three_reg;
  assign tif.is_io = i_is_io;
  assign tif.wide = i_wide;
  assign tif.paged = i_paged;
  assign tif.io_addr = i_io_addr;
  assign tif.tgt = i_tgt;

  rcwt_timing u_timing (
    .t (tif.sel)
  );

  // Indexed configuration writes; bit 1 of ROM config two is held for software
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rom_config_two_reg <= `RCWT_REG_RESET;
      command_delay_ctl_reg <= `RCWT_REG_RESET;
      io_wait_select_reg <= `RCWT_REG_RESET;
      memory_wait_select_one_reg <= `RCWT_REG_RESET;
      memory_wait_select_two_reg <= `RCWT_REG_RESET;
      wait_control_reg <= `RCWT_REG_RESET;
      misc_five_ctl_reg <= `RCWT_REG_RESET;
      rom_config_three_reg <= `RCWT_REG_RESET;
    end else if (i_cfg_wr) begin
      case (i_cfg_index)
        `RCWT_IDX_ROM_CFG2: rom_config_two_reg <= i_cfg_wdata;
        `RCWT_IDX_CMD_DLY: command_delay_ctl_reg <= i_cfg_wdata;
        `RCWT_IDX_IO_WAIT: io_wait_select_reg <= i_cfg_wdata;
        `RCWT_IDX_MEM_WAIT1: memory_wait_select_one_reg <= i_cfg_wdata;
        `RCWT_IDX_MEM_WAIT2: memory_wait_select_two_reg <= i_cfg_wdata;
        `RCWT_IDX_WAIT_CTL: wait_control_reg <= i_cfg_wdata;
        `RCWT_IDX_MISC5: misc_five_ctl_reg <= i_cfg_wdata;
        `RCWT_IDX_ROM_CFG3: rom_config_three_reg <= i_cfg_wdata;
        default: ;
      endcase
    end
  end

  // Read data follows the index one clock later; unknown indexes read zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cfg_rdata <= 8'h00;
    end else begin
      case (i_cfg_index)
        `RCWT_IDX_ROM_CFG2: o_cfg_rdata <= rom_config_two_reg;
        `RCWT_IDX_CMD_DLY: o_cfg_rdata <= command_delay_ctl_reg;
        `RCWT_IDX_IO_WAIT: o_cfg_rdata <= io_wait_select_reg;
        `RCWT_IDX_MEM_WAIT1: o_cfg_rdata <= memory_wait_select_one_reg;
        `RCWT_IDX_MEM_WAIT2: o_cfg_rdata <= memory_wait_select_two_reg;
        `RCWT_IDX_WAIT_CTL: o_cfg_rdata <= wait_control_reg;
        `RCWT_IDX_MISC5: o_cfg_rdata <= misc_five_ctl_reg;
        `RCWT_IDX_ROM_CFG3: o_cfg_rdata <= rom_config_three_reg;
        default: o_cfg_rdata <= 8'h00;
      endcase
    end
  end

  // Pin levels cross in through two flops each
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stop_m_reg <= 1'b0;
      stop_s_reg <= 1'b0;
      max_m_reg <= 1'b0;
      max_s_reg <= 1'b0;
    end else begin
      stop_m_reg <= i_cpu_clk_stop;
      stop_s_reg <= stop_m_reg;
      max_m_reg <= i_max_isa;
      max_s_reg <= max_m_reg;
    end
  end

  // Low-speed bus half period divider; the bus clock toggles on each half tick
  assign half_tick = (div_reg == 4'(HALF_DIV - 1));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= 4'd0;
      o_bus_clk <= 1'b0;
    end else if (half_tick) begin
      div_reg <= 4'd0;
      o_bus_clk <= ~o_bus_clk;
    end else begin
      div_reg <= div_reg + 4'd1;
    end
  end

  // Fast ROM cycles advance every core clock, others every bus half period
  assign step = fast_reg ? 1'b1 : half_tick;

  // Cycle sequencer; position counts steps from the address phase, half bus clocks on slow cycles and core clocks on fast ones
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= S_IDLE;
      h_reg <= 4'd0;
      start_reg <= 4'd0;
      end_reg <= 4'd0;
      dly_reg <= 3'd0;
      ws_reg <= 3'd0;
      fast_reg <= 1'b0;
      maxisa_reg <= 1'b0;
      tgt_reg <= TGT_ISA;
      io_reg <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          // A stopped CPU clock refuses new cycles
          if (i_req && !stop_s_reg) begin
            dly_reg <= tif.dly_halves;
            ws_reg <= tif.waits;
            fast_reg <= tif.fast;
            maxisa_reg <= max_s_reg;
            tgt_reg <= i_tgt;
            io_reg <= i_is_io;
            start_reg <= `RCWT_ADDR_HALVES + {1'b0, tif.dly_halves};
            end_reg <= 4'd4 + {tif.waits, 1'b0};
            state_reg <= S_ARM;
          end
        end
        S_ARM: begin
          // Slow cycles start on a rising bus clock so half steps hit falling edges
          if (fast_reg || (half_tick && !o_bus_clk)) begin
            h_reg <= 4'd0;
            state_reg <= S_RUN;
          end
        end
        S_RUN: begin
          if (step) begin
            if (h_reg == end_reg - 4'd1) begin
              state_reg <= S_IDLE;
              o_done <= 1'b1;
            end else begin
              h_reg <= h_reg + 4'd1;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Command window: opens after the delay, closes at the wait-state end
  assign cmd_on = (state_reg == S_RUN) && (h_reg >= start_reg) && (h_reg < end_reg);
  assign run_addr = (state_reg == S_RUN) && (h_reg == 4'd0);

  // Registered bus outputs; selects either gate with the command or decode only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy <= 1'b0;
      o_addr_en <= 1'b0;
      o_bale <= 1'b0;
      o_cmd_n <= 1'b1;
      o_bios_rom_select_n <= 1'b1;
      o_dos_rom_select_n <= 1'b1;
    end else begin
      o_busy <= (state_reg != S_IDLE);
      o_addr_en <= (state_reg == S_RUN);
      o_bale <= run_addr && !(fast_reg && maxisa_reg);
      o_cmd_n <= !cmd_on;
      o_bios_rom_select_n <= stop_s_reg || !((state_reg == S_RUN) && !io_reg &&
                             tgt_reg == TGT_BIOS &&
                             (cmd_on || misc_five_ctl_reg[`RCWT_MISC5_DECODE]));
      o_dos_rom_select_n <= stop_s_reg || !((state_reg == S_RUN) && !io_reg &&
                            tgt_reg == TGT_DOS &&
                            (cmd_on || rom_config_three_reg[`RCWT_ROM3_DECODE]));
    end
  end

  // Checks on timing and select behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  logic accept;
  assign accept = (state_reg == S_IDLE) && i_req && !stop_s_reg;

  property p_cmd_open;
    $fell(o_cmd_n) |-> $past(h_reg) == `RCWT_ADDR_HALVES + {1'b0, dly_reg};
  endproperty
  a_cmd_open: assert property (p_cmd_open) else $error("command opened off delay");

  // Close must follow the final step of the wait-state count; ws read before a new accept
  property p_cmd_close;
    $rose(o_cmd_n) |-> $past(o_done) && $past(h_reg) == 4'd3 + {$past(ws_reg, 2), 1'b0};
  endproperty
  a_cmd_close: assert property (p_cmd_close) else $error("command closed off wait end");

  property p_isa_delay;
    accept && !i_is_io && !i_wide && i_tgt == TGT_ISA
      |=> dly_reg == ($past(command_delay_ctl_reg[2]) ? 3'd1 : 3'd2);
  endproperty
  a_isa_delay: assert property (p_isa_delay) else $error("ISA delay wrong");

  property p_io16_waits;
    accept && i_is_io && i_wide |=> ws_reg == ($past(wait_control_reg[2]) ? 3'd4 : 3'd3);
  endproperty
  a_io16_waits: assert property (p_io16_waits) else $error("16-bit I/O waits wrong");

  property p_bios_slow;
    accept && !i_is_io && i_tgt == TGT_BIOS && !misc_five_ctl_reg[6] |=> !fast_reg;
  endproperty
  a_bios_slow: assert property (p_bios_slow) else $error("BIOS fast while disabled");

  property p_bios_fast_ws;
    accept && !i_is_io && i_tgt == TGT_BIOS && misc_five_ctl_reg[6]
      |=> fast_reg && ws_reg == 3'd4 - {1'b0, $past(misc_five_ctl_reg[5:4])};
  endproperty
  a_bios_fast_ws: assert property (p_bios_fast_ws) else $error("fast BIOS waits wrong");

  property p_dos_fast_ws;
    accept && !i_is_io && i_tgt == TGT_DOS && rom_config_three_reg[7]
      |=> fast_reg && ws_reg == 3'd4 - {1'b0, $past(rom_config_three_reg[6:5])};
  endproperty
  a_dos_fast_ws: assert property (p_dos_fast_ws) else $error("fast DOS waits wrong");

  property p_no_bale_fast;
    fast_reg && maxisa_reg && $past(state_reg) == S_RUN |-> !o_bale;
  endproperty
  a_no_bale_fast: assert property (p_no_bale_fast) else $error("latch pulsed on fast ROM");

  property p_stop_high;
    stop_s_reg && $past(stop_s_reg) |-> o_bios_rom_select_n && o_dos_rom_select_n;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("select low with clock stopped");

  c_fast_done: cover property (fast_reg && o_done);
  c_slow_io_done: cover property (!fast_reg && io_reg && o_done);
  c_long_delay: cover property ($fell(o_cmd_n) && dly_reg == 3'd4);

endmodule

// [hdl/rcwt_defs.svh]
// Register indexes, field positions, reset values and timing counts of the cycle timer
`ifndef RCWT_DEFS_SVH
`define RCWT_DEFS_SVH

// Configuration register indexes
`define RCWT_IDX_ROM_CFG2 8'h51
`define RCWT_IDX_CMD_DLY 8'h60
`define RCWT_IDX_IO_WAIT 8'h61
`define RCWT_IDX_MEM_WAIT1 8'h62
`define RCWT_IDX_WAIT_CTL 8'h63
`define RCWT_IDX_MISC5 8'hb3
`define RCWT_IDX_ROM_CFG3 8'hb8
`define RCWT_IDX_MEM_WAIT2 8'h66

// Reset value shared by every register; fast ROM modes start disabled
`define RCWT_REG_RESET 8'h00

// Field positions
`define RCWT_CMD_ISA_HALF 2
`define RCWT_CMD_BIOS_HI 7
`define RCWT_CMD_BIOS_LO 4
`define RCWT_MW2_DOS_FOLLOW 6
`define RCWT_MW2_DOS_HALF 2
`define RCWT_WCTL_IO16 2
`define RCWT_WCTL_IOINT 3
`define RCWT_MISC5_DECODE 2
`define RCWT_MISC5_FAST 6
`define RCWT_ROM3_DECODE 4
`define RCWT_ROM3_FAST 7

// Timing: fast clock and low-speed ROM/ISA bus rate in kHz
`define RCWT_CLK_KHZ 50000
`define RCWT_SLOW_BUS_KHZ 9200
// Core clocks per bus half period, rounded up so the bus never runs fast
`define RCWT_HALF_DIV ((`RCWT_CLK_KHZ + 2 * `RCWT_SLOW_BUS_KHZ - 1) / (2 * `RCWT_SLOW_BUS_KHZ))
// Address phase length in half bus clocks
`define RCWT_ADDR_HALVES 4'd2

`endif

// [hdl/rcwt_pkg.sv]
// Types and shared decode functions of the cycle timer
package rcwt_pkg;

  // Which decode target a memory cycle hits
  typedef enum logic [1:0] {TGT_ISA, TGT_DOS, TGT_BIOS} rcwt_tgt_t;

  // Cycle sequencer states
  typedef enum logic [1:0] {S_IDLE, S_ARM, S_RUN} rcwt_state_t;

  // Fast ROM select wait code: 00 gives 4 down to 11 giving 1
  function automatic logic [2:0] rcwt_fast_waits(input logic [1:0] code);
    rcwt_fast_waits = 3'd4 - {1'b0, code};
  endfunction

  // Two-bit code that adds to a base count
  function automatic logic [2:0] rcwt_code_plus(input logic [1:0] code, input logic [2:0] base);
    rcwt_code_plus = {1'b0, code} + base;
  endfunction

endpackage

// [hdl/rcwt_tim_if.sv]
// Carrier between the cycle sequencer and its timing selector
`timescale 1ns/1ps
interface rcwt_tim_if;
  import rcwt_pkg::*;
  logic [7:0] cmd_dly;
  logic [7:0] io_wait;
  logic [7:0] mem_wait1;
  logic [7:0] mem_wait2;
  logic [7:0] wait_ctl;
  logic [7:0] misc5;
  logic [7:0] rom_cfg3;
  logic is_io;
  logic wide;
  logic paged;
  logic [9:0] io_addr;
  rcwt_tgt_t tgt;
  logic [2:0] dly_halves;
  logic [2:0] waits;
  logic fast;
  modport seq (output cmd_dly, io_wait, mem_wait1, mem_wait2, wait_ctl, misc5, rom_cfg3,
               is_io, wide, paged, io_addr, tgt, input dly_halves, waits, fast);
  modport sel (input cmd_dly, io_wait, mem_wait1, mem_wait2, wait_ctl, misc5, rom_cfg3,
               is_io, wide, paged, io_addr, tgt, output dly_halves, waits, fast);
endinterface

// [hdl/rcwt_timing.sv]
// Selects command delay, wait states and clock speed for the pending cycle
`timescale 1ns/1ps
`include "rcwt_defs.svh"
module rcwt_timing (
  rcwt_tim_if.sel t
);
  import rcwt_pkg::*;

  // Delay in half bus clocks and wait states by cycle class
  always_comb begin
    logic [2:0] isa_ws;
    isa_ws = rcwt_code_plus(t.mem_wait1[1:0], 3'd2);
    t.dly_halves = 3'd1;
    t.waits = isa_ws;
    t.fast = 1'b0;
    if (t.is_io) begin
      if (t.wide) begin
        t.dly_halves = 3'd1;
        t.waits = t.wait_ctl[`RCWT_WCTL_IO16] ? 3'd4 : 3'd3;
      end else if (t.io_addr < 10'h100) begin
        t.dly_halves = 3'd1;
        t.waits = t.wait_ctl[`RCWT_WCTL_IOINT] ? 3'd4 : 3'd2;
      end else begin
        // 00 half clock, 01 one clock, 1x two clocks
        case (t.cmd_dly[1:0])
          2'b00: t.dly_halves = 3'd1;
          2'b01: t.dly_halves = 3'd2;
          default: t.dly_halves = 3'd4;
        endcase
        if (t.io_addr[9:3] == 7'h7e) begin
          t.waits = rcwt_code_plus(t.io_wait[1:0], 3'd2);
        end else if (t.io_addr[9:3] == 7'h3e) begin
          t.waits = rcwt_code_plus(t.io_wait[3:2], 3'd2);
        end else begin
          t.waits = rcwt_code_plus(t.io_wait[5:4], 3'd2);
        end
      end
    end else if (t.wide) begin
      t.dly_halves = 3'd0;
      t.waits = rcwt_code_plus(t.mem_wait1[3:2], 3'd1);
    end else begin
      case (t.tgt)
        TGT_ISA: begin
          t.dly_halves = t.cmd_dly[`RCWT_CMD_ISA_HALF] ? 3'd1 : 3'd2;
          t.waits = isa_ws;
        end
        TGT_BIOS: begin
          t.dly_halves = 3'd1;
          if (t.paged) begin
            t.waits = isa_ws;
          end else begin
            t.waits = (t.cmd_dly[`RCWT_CMD_BIOS_HI] | t.cmd_dly[`RCWT_CMD_BIOS_LO]) ?
                      3'd3 : 3'd2;
          end
        end
        TGT_DOS: begin
          // Follow the ISA delay, or choose half or none locally
          if (t.mem_wait2[`RCWT_MW2_DOS_FOLLOW]) begin
            t.dly_halves = t.cmd_dly[`RCWT_CMD_ISA_HALF] ? 3'd1 : 3'd2;
          end else begin
            t.dly_halves = t.mem_wait2[`RCWT_MW2_DOS_HALF] ? 3'd1 : 3'd0;
          end
          if (t.mem_wait2[2:0] >= 3'd1 && t.mem_wait2[2:0] <= 3'd4) begin
            t.waits = t.mem_wait2[2:0];
          end else begin
            t.waits = isa_ws;
          end
        end
        default: begin
          t.dly_halves = 3'd1;
          t.waits = isa_ws;
        end
      endcase
    end
    // Fast ROM selects override the wait count and run on the core clock
    if (!t.is_io && t.tgt == TGT_BIOS && t.misc5[`RCWT_MISC5_FAST]) begin
      t.fast = 1'b1;
      t.waits = rcwt_fast_waits(t.misc5[5:4]);
    end else if (!t.is_io && t.tgt == TGT_DOS && t.rom_cfg3[`RCWT_ROM3_FAST]) begin
      t.fast = 1'b1;
      t.waits = rcwt_fast_waits(t.rom_cfg3[6:5]);
    end
  end

endmodule

// [verif/rcwt_periph_model.sv]
// Passive ROM and ISA peripheral that times every bus cycle it sees
`timescale 1ns/1ps
module rcwt_periph_model (
  input logic i_clk,
  input logic i_addr_en,
  input logic i_bale,
  input logic i_cmd_n,
  input logic i_bios_n,
  input logic i_dos_n,
  input logic i_bus_clk,
  output logic [15:0] o_t_dly,
  output logic [15:0] o_t_end,
  output logic o_bale_seen,
  output logic o_bios_seen,
  output logic o_dos_seen,
  output logic o_flip
);
  logic addr_q = 1'b0;
  logic cmd_q = 1'b1;
  logic bclk_a = 1'b0;
  logic [15:0] cnt = 16'h0000;
  // Stopwatch restarts when an address goes out; all marks count core clocks from there
  always @(posedge i_clk) begin
    addr_q <= i_addr_en;
    cmd_q <= i_cmd_n;
    cnt <= cnt + 16'h0001;
    if (i_addr_en && !addr_q) begin
      cnt <= 16'h0001;
      bclk_a <= i_bus_clk;
      o_bale_seen <= i_bale;
      o_bios_seen <= !i_bios_n;
      o_dos_seen <= !i_dos_n;
    end else begin
      o_bale_seen <= o_bale_seen | i_bale;
      o_bios_seen <= o_bios_seen | !i_bios_n;
      o_dos_seen <= o_dos_seen | !i_dos_n;
    end
    // Bus clock phase at command start tells which edge launched it
    if (!i_cmd_n && cmd_q) begin
      o_t_dly <= cnt;
      o_flip <= i_bus_clk ^ bclk_a;
    end
    if (i_cmd_n && !cmd_q) o_t_end <= cnt;
  end
endmodule

// [verif/tb_rom_isa_cycle_wait_timing.sv]
// Self-checking bench for the ROM and ISA cycle timer
`timescale 1ns/1ps
`include "rcwt_defs.svh"
module tb_rom_isa_cycle_wait_timing;
  import rcwt_pkg::*;
  // Shorter half period keeps slow cycles brief
  localparam int HD = 2;
  logic i_clk, i_rstn, i_cfg_wr, i_req, i_is_io, i_wide, i_paged, i_cpu_clk_stop, i_max_isa;
  logic [7:0] i_cfg_index, i_cfg_wdata, o_cfg_rdata;
  logic [9:0] i_io_addr;
  rcwt_tgt_t i_tgt;
  logic o_busy, o_done, o_bus_clk, o_addr_en, o_bale, o_cmd_n, o_bios_n, o_dos_n;
  logic [15:0] t_dly, t_end, e_dly, e_ws;
  logic bale_seen, bios_seen, dos_seen, flip, e_fast;
  logic [7:0] cd, iw, m1, m2, wc, m5, r3;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] idx [8] = '{`RCWT_IDX_ROM_CFG2, `RCWT_IDX_CMD_DLY, `RCWT_IDX_IO_WAIT,
    `RCWT_IDX_MEM_WAIT1, `RCWT_IDX_WAIT_CTL, `RCWT_IDX_MISC5, `RCWT_IDX_ROM_CFG3,
    `RCWT_IDX_MEM_WAIT2};
  logic [9:0] io_a [4] = '{10'h060, 10'h3f2, 10'h1f3, 10'h278};
  logic [7:0] m2v [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h40, 8'h44, 8'h47};
  rcwt_tgt_t tg [3] = '{TGT_ISA, TGT_DOS, TGT_BIOS};

  rcwt_cycle_timer #(.HALF_DIV(HD)) i_rcwt_cycle_timer (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_wr(i_cfg_wr), .i_cfg_index(i_cfg_index),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_req(i_req), .i_is_io(i_is_io),
    .i_wide(i_wide), .i_paged(i_paged), .i_io_addr(i_io_addr), .i_tgt(i_tgt),
    .i_cpu_clk_stop(i_cpu_clk_stop), .i_max_isa(i_max_isa), .o_busy(o_busy),
    .o_done(o_done), .o_bus_clk(o_bus_clk), .o_addr_en(o_addr_en), .o_bale(o_bale),
    .o_cmd_n(o_cmd_n), .o_bios_rom_select_n(o_bios_n), .o_dos_rom_select_n(o_dos_n));

  rcwt_periph_model i_rcwt_periph_model (
    .i_clk(i_clk), .i_addr_en(o_addr_en), .i_bale(o_bale), .i_cmd_n(o_cmd_n),
    .i_bios_n(o_bios_n), .i_dos_n(o_dos_n), .i_bus_clk(o_bus_clk), .o_t_dly(t_dly),
    .o_t_end(t_end), .o_bale_seen(bale_seen), .o_bios_seen(bios_seen),
    .o_dos_seen(dos_seen), .o_flip(flip));

  // Core clock, 20 ns period
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Every driver change lands 1 ns after a rising edge
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Register write, mirrored into the bench's own copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cfg_wr = 1'b1;
    i_cfg_index = a;
    i_cfg_wdata = d;
    tk(1);
    i_cfg_wr = 1'b0;
    // Idle edge between writes so the strobe never toggles twice in one step
    tk(1);
    case (a)
      `RCWT_IDX_CMD_DLY: cd = d;
      `RCWT_IDX_IO_WAIT: iw = d;
      `RCWT_IDX_MEM_WAIT1: m1 = d;
      `RCWT_IDX_MEM_WAIT2: m2 = d;
      `RCWT_IDX_WAIT_CTL: wc = d;
      `RCWT_IDX_MISC5: m5 = d;
      `RCWT_IDX_ROM_CFG3: r3 = d;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_cfg_index = a;
    tk(2);
    chk("cfg_rdata", e, o_cfg_rdata);
  endtask

  // One bus cycle, timed by the peripheral model against the expected figures
  task automatic run(input logic io, wd, pg, input logic [9:0] a, input rcwt_tgt_t t);
    logic [15:0] h;
    int k;
    e_fast = 1'b0;
    if (io) begin
      e_dly = 3'h1;
      if (wd) e_ws = wc[2] ? 3'h4 : 3'h3;
      else if (a < 10'h100) e_ws = wc[3] ? 3'h4 : 3'h2;
      else begin
        e_dly = cd[1] ? 3'h4 : (cd[0] ? 3'h2 : 3'h1);
        if (a[9:3] == 7'h7e) e_ws = iw[1:0] + 3'h2;
        else if (a[9:3] == 7'h3e) e_ws = iw[3:2] + 3'h2;
        else e_ws = iw[5:4] + 3'h2;
      end
    end else if (wd) begin
      e_dly = 3'h0;
      e_ws = m1[3:2] + 3'h1;
    end else if (t == TGT_ISA) begin
      e_dly = cd[2] ? 3'h1 : 3'h2;
      e_ws = m1[1:0] + 3'h2;
    end else if (t == TGT_DOS) begin
      e_dly = m2[6] ? (cd[2] ? 3'h1 : 3'h2) : (m2[2] ? 3'h1 : 3'h0);
      e_ws = (m2[2:0] inside {[1:4]}) ? m2[2:0] : m1[1:0] + 3'h2;
    end else begin
      e_dly = 3'h1;
      e_ws = pg ? m1[1:0] + 3'h2 : ((cd[7] | cd[4]) ? 3'h3 : 3'h2);
    end
    if (!io && t == TGT_BIOS && m5[6]) begin
      e_fast = 1'b1;
      e_ws = 3'h4 - m5[5:4];
    end
    if (!io && t == TGT_DOS && r3[7]) begin
      e_fast = 1'b1;
      e_ws = 3'h4 - r3[6:5];
    end
    i_req = 1'b1;
    i_is_io = io;
    i_wide = wd;
    i_paged = pg;
    i_io_addr = a;
    i_tgt = t;
    tk(1);
    i_req = 1'b0;
    k = 0;
    while (o_done !== 1'b1 && k < 400) begin
      tk(1);
      k++;
    end
    chk("done", 1'b1, o_done);
    tk(2);
    h = e_fast ? 16'h0001 : HD[15:0];
    chk("cmd_delay", (16'h0002 + e_dly) * h, t_dly);
    chk("cycle_end", (16'h0004 + 2 * e_ws) * h, t_end);
    if (!e_fast) chk("half_edge", e_dly[0], flip);
    chk("bale", !(e_fast && i_max_isa), bale_seen);
    chk("bios_select", !io && t == TGT_BIOS, bios_seen);
    chk("dos_select", !io && t == TGT_DOS, dos_seen);
  endtask

  initial begin
    {i_cfg_wr, i_req, i_is_io, i_wide, i_paged, i_cpu_clk_stop, i_max_isa} = 7'h00;
    {i_cfg_index, i_cfg_wdata, i_io_addr} = 26'h000_0000;
    i_tgt = TGT_ISA;
    {cd, iw, m1, m2, wc, m5, r3} = 56'h0000_0000_0000_00;
    i_rstn = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    tk(1);
    // Reset values, readback, unmapped index
    foreach (idx[i]) rd(idx[i], `RCWT_REG_RESET);
    foreach (idx[i]) begin
      wr(idx[i], 8'ha5 ^ 8'(i));
      rd(idx[i], 8'ha5 ^ 8'(i));
      wr(idx[i], 8'h00);
    end
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h00);
    // 8-bit ISA memory, both delays and all wait codes
    for (int c = 0; c < 8; c++) begin
      wr(`RCWT_IDX_CMD_DLY, c[2] ? 8'h04 : 8'h00);
      wr(`RCWT_IDX_MEM_WAIT1, 8'(c[1:0]));
      run(1'b0, 1'b0, 1'b0, 10'h000, TGT_ISA);
    end
    // 8-bit DOS ROM delay and wait choices
    for (int i = 0; i < 9; i++) begin
      wr(`RCWT_IDX_CMD_DLY, i[0] ? 8'h04 : 8'h00);
      wr(`RCWT_IDX_MEM_WAIT2, m2v[i]);
      run(1'b0, 1'b0, 1'b0, 10'h000, TGT_DOS);
    end
    // BIOS ROM unpaged and paged
    for (int c = 0; c < 4; c++) begin
      wr(`RCWT_IDX_CMD_DLY, {c[1], 2'h0, c[0], 4'h0});
      run(1'b0, 1'b0, 1'b0, 10'h000, TGT_BIOS);
      run(1'b0, 1'b0, 1'b1, 10'h000, TGT_BIOS);
    end
    // 16-bit memory on every target
    for (int c = 0; c < 4; c++) begin
      wr(`RCWT_IDX_MEM_WAIT1, {4'h0, c[1:0], 2'h0});
      run(1'b0, 1'b1, 1'b0, 10'h000, tg[c % 3]);
    end
    // I/O ranges, delay codes and wait fields
    for (int c = 0; c < 4; c++) begin
      wr(`RCWT_IDX_CMD_DLY, 8'(c));
      wr(`RCWT_IDX_IO_WAIT, 8'(c * 21));
      wr(`RCWT_IDX_WAIT_CTL, {4'h0, c[1:0], 2'h0});
      foreach (io_a[j]) run(1'b1, 1'b0, 1'b0, io_a[j], TGT_ISA);
      run(1'b1, 1'b1, 1'b0, 10'h278, TGT_ISA);
    end
    // Fast BIOS select, with and without max ISA mode
    for (int c = 0; c < 8; c++) begin
      i_max_isa = c[2];
      wr(`RCWT_IDX_MISC5, {2'h1, c[1:0], 4'h0});
      tk(3);
      run(1'b0, c[0], 1'b0, 10'h000, TGT_BIOS);
    end
    wr(`RCWT_IDX_MISC5, 8'h00);
    // Fast DOS select; no 16-bit peers on this bench
    wr(`RCWT_IDX_ROM_CFG2, 8'h02);
    for (int c = 0; c < 8; c++) begin
      i_max_isa = c[2];
      wr(`RCWT_IDX_ROM_CFG3, {1'b1, c[1:0], 5'h00});
      tk(3);
      run(1'b0, c[0], 1'b0, 10'h000, TGT_DOS);
    end
    // Decode-only BIOS select is low before the command; a stop mid-cycle parks it high
    wr(`RCWT_IDX_MISC5, 8'h04);
    wr(`RCWT_IDX_ROM_CFG3, 8'h10);
    {i_is_io, i_wide, i_paged} = 3'h0;
    i_tgt = TGT_BIOS;
    i_req = 1'b1;
    tk(1);
    i_req = 1'b0;
    tk(6);
    chk("bios_select_n", 1'b0, o_bios_n);
    chk("cmd_n", 1'b1, o_cmd_n);
    tk(2);
    i_cpu_clk_stop = 1'b1;
    tk(3);
    chk("busy", 1'b1, o_busy);
    chk("bios_select_n", 1'b1, o_bios_n);
    tk(16);
    // New requests are refused while the clock stays stopped
    i_req = 1'b1;
    tk(1);
    i_req = 1'b0;
    tk(20);
    chk("busy", 1'b0, o_busy);
    chk("bios_select_n", 1'b1, o_bios_n);
    chk("dos_select_n", 1'b1, o_dos_n);
    i_cpu_clk_stop = 1'b0;
    tk(4);
    stop_test();
  end
endmodule
